// [common/emb_cfg.svh]
// constants for the external memory bus port
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
`define EMB_PHASES_PER_MC    4'd12
`define EMB_LAST_PHASE       4'd11
`define EMB_HALF_PHASE       4'd6
`define EMB_ALE_HIGH_SUBS    4'd2
`define EMB_ADDR_HOLD_SUBS   4'd3
`define EMB_STROBE_LO_SUBS   4'd5
`define EMB_RESET_MC         2
`define EMB_RESET_CYCLES     (`EMB_RESET_MC * 12)
`define EMB_OFS_LATCH        12'h000
`define EMB_OFS_FETCH        12'h004
`define EMB_OFS_REQ          12'h008
`define EMB_OFS_STAT         12'h00C
`define EMB_OFS_CODE         12'h010
`define EMB_OFS_PINS         12'h014
`define EMB_OFS_MODE         12'h018
`define EMB_IDX_ALE_CTRL     12'h08E
`define EMB_OFS_ALE_CTRL     (`EMB_IDX_ALE_CTRL * 4)
`define EMB_LATCH_RESET      32'hFFFF_FFFF
`define EMB_REQ_WRITE_BIT    24
`define EMB_REQ_INDIR_BIT    25
`define EMB_REQ_CMOVE_BIT    26
`define EMB_STAT_BUSY_BIT    8
`define EMB_STAT_DONE_BIT    9
`define EMB_ALE_DIS_BIT      0
`endif

// [common/emb_pkg.sv]
// types for the external memory bus port
package emb_pkg;
    typedef enum logic [0:0] {CYC_NORMAL, CYC_DATA} emb_cyc_e;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] wpu;
    } emb_pins_s;
    typedef struct packed {
        logic       code_move;
        logic       indirect;
        logic       write;
        logic [7:0] wdata;
        logic [15:0] addr;
    } emb_req_s;
endpackage : emb_pkg

// [rtl/emb_port.sv]
// external memory bus port with apb register slave
`timescale 1ns/1ps
`include "emb_cfg.svh"
module emb_port (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              reset_pin,
    input  wire logic              external_fetch_select,
    input  wire logic              lock_programmed,
    input  wire logic [7:0]        p0_in,
    input  wire logic [7:0]        p1_in,
    input  wire logic [7:0]        p2_in,
    input  wire logic [7:0]        p3_in,
    output emb_pkg::emb_pins_s     p0_pins,
    output emb_pkg::emb_pins_s     p1_pins,
    output emb_pkg::emb_pins_s     p2_pins,
    output emb_pkg::emb_pins_s     p3_pins,
    output logic                   ale_out,
    output logic                   ale_oe,
    output logic                   ale_wpu,
    output logic                   program_fetch_strobe_n
);
    function automatic logic [2:0] reg_decode(input logic [11:0] a);
        logic [2:0] r;
        r = 3'd0;
        if (a == `EMB_OFS_LATCH) r = 3'd1;
        if (a == `EMB_OFS_FETCH) r = 3'd2;
        if (a == `EMB_OFS_REQ) r = 3'd3;
        if (a == `EMB_OFS_STAT) r = 3'd4;
        if (a == `EMB_OFS_CODE) r = 3'd5;
        if (a == `EMB_OFS_PINS) r = 3'd6;
        if (a == 12'(`EMB_OFS_ALE_CTRL)) r = 3'd7;
        if (a == `EMB_OFS_MODE) r = 3'd0;
        return r;
    endfunction : reg_decode

    // quasi-bidirectional pin: strong low, weak high
    function automatic emb_pkg::emb_pins_s quasi(input logic [7:0] l);
        emb_pkg::emb_pins_s p;
        p.out = l;
        p.oe  = ~l;
        p.wpu = l;
        return p;
    endfunction : quasi

    logic [34:0]        sync1_q;
    logic [34:0]        sync2_q;
    logic               rst_s;
    logic               efs_s;
    logic               lock_s;
    logic [31:0]        pins_s;
    logic [4:0]         rst_cnt_q;
    logic               int_rst;
    logic               efs_latch_q;
    logic               ext_exec_q;
    logic               ext_exec;
    logic               fetch_q;
    logic               ale_dis_eff_q;
    logic [3:0]         phase_q;
    logic               half;
    logic [3:0]         sub;
    emb_pkg::emb_cyc_e  cyc_q;
    emb_pkg::emb_req_s  req_q;
    logic               req_pend_q;
    logic               busy;
    logic [15:0]        pc_q;
    logic [7:0]         code_q;
    logic [7:0]         rdata_q;
    logic               done_q;
    logic [31:0]        latch_q;
    logic               ale_dis_q;
    logic               ale_block;
    logic               bus_active;
    logic               data_cyc;
    logic [2:0]         sel;
    logic               wr_en;
    logic [15:0]        addr;
    logic               wr_n;
    logic               rd_n;
    emb_pkg::emb_pins_s p0_d;
    emb_pkg::emb_pins_s p1_d;
    emb_pkg::emb_pins_s p2_d;
    emb_pkg::emb_pins_s p3_d;
    logic               ale_out_d;
    logic               ale_oe_d;
    logic               ale_wpu_d;
    logic               program_fetch_strobe_d;

    // every pin passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle pin levels, so no false strap or reset after release
            sync1_q <= 35'h2_FFFF_FFFF;
            sync2_q <= 35'h2_FFFF_FFFF;
        end else begin
            sync1_q <= {reset_pin, external_fetch_select, lock_programmed,
                        p3_in, p2_in, p1_in, p0_in};
            sync2_q <= sync1_q;
        end
    end
    assign rst_s  = sync2_q[34];
    assign efs_s  = sync2_q[33];
    assign lock_s = sync2_q[32];
    assign pins_s = sync2_q[31:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q <= 5'h00;
        end else if (!rst_s) begin
            rst_cnt_q <= 5'h00;
        end else if (rst_cnt_q != 5'(`EMB_RESET_CYCLES)) begin
            rst_cnt_q <= rst_cnt_q + 5'h01;
        end
    end
    assign int_rst = rst_s && (rst_cnt_q == 5'(`EMB_RESET_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            efs_latch_q <= 1'b1;
        end else if (rst_s) begin
            efs_latch_q <= efs_s;
        end
    end
    // select picks code source
    // source switches only at half ends so strobes stay whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_exec_q <= 1'b0;
        end else if (sub == `EMB_STROBE_LO_SUBS) begin
            ext_exec_q <= lock_s ? ~efs_latch_q : ~efs_s;
        end
    end
    assign ext_exec = ext_exec_q;

    // machine cycle of twelve phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 4'h0;
            cyc_q   <= emb_pkg::CYC_NORMAL;
        end else if (int_rst) begin
            phase_q <= 4'h0;
            cyc_q   <= emb_pkg::CYC_NORMAL;
        end else if (phase_q == `EMB_LAST_PHASE) begin
            phase_q <= 4'h0;
            cyc_q   <= req_pend_q ? emb_pkg::CYC_DATA : emb_pkg::CYC_NORMAL;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end
    assign half = phase_q >= `EMB_HALF_PHASE;
    assign sub  = half ? phase_q - `EMB_HALF_PHASE : phase_q;
    assign data_cyc = cyc_q == emb_pkg::CYC_DATA;
    assign busy = req_pend_q || data_cyc;

    assign sel    = reg_decode(paddr);
    assign wr_en  = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (sel == 3'd0)
                     && (paddr != `EMB_OFS_MODE || pwrite);

    // request refused silently while one is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_pend_q <= 1'b0;
            req_q      <= '0;
        end else if (int_rst) begin
            req_pend_q <= 1'b0;
        end else if (wr_en && sel == 3'd3 && !busy) begin
            req_pend_q <= 1'b1;
            req_q      <= emb_pkg::emb_req_s'(pwdata[26:0]);
        end else if (phase_q == `EMB_LAST_PHASE) begin
            req_pend_q <= 1'b0;
        end
    end

    // software write of the address wins over increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= 16'h0000;
        end else if (int_rst) begin
            pc_q <= 16'h0000;
        end else if (wr_en && sel == 3'd2) begin
            pc_q <= pwdata[15:0];
        end else if (!data_cyc && ext_exec && sub == `EMB_STROBE_LO_SUBS) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    // code byte taken one cycle after strobe end
    // synced pins lag two cycles behind the strobed byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_q <= 1'b0;
            code_q  <= 8'h00;
        end else begin
            fetch_q <= !data_cyc && ext_exec
                       && sub == `EMB_STROBE_LO_SUBS;
            if (fetch_q) begin
                code_q <= pins_s[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 8'h00;
        end else if (data_cyc && !req_q.write && half
                     && sub == `EMB_STROBE_LO_SUBS - 4'h1) begin
            rdata_q <= pins_s[7:0];
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (int_rst) begin
            done_q <= 1'b0;
        end else if (data_cyc && phase_q == `EMB_LAST_PHASE) begin
            done_q <= 1'b1;
        end else if (wr_en && sel == 3'd4 && pwdata[`EMB_STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= `EMB_LATCH_RESET;
        end else if (int_rst) begin
            latch_q <= `EMB_LATCH_RESET;
        end else if (wr_en && sel == 3'd1) begin
            latch_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_dis_q <= 1'b0;
        end else if (int_rst) begin
            ale_dis_q <= 1'b0;
        end else if (wr_en && sel == 3'd7) begin
            ale_dis_q <= pwdata[`EMB_ALE_DIS_BIT];
        end
    end

    // disable acts at half ends only, never clips a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_dis_eff_q <= 1'b0;
        end else if (int_rst) begin
            ale_dis_eff_q <= 1'b0;
        end else if (sub == `EMB_STROBE_LO_SUBS) begin
            ale_dis_eff_q <= ale_dis_q;
        end
    end

    // read data sampled in setup so prdata is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (sel)
                3'd1: prdata <= latch_q;
                3'd2: prdata <= {16'h0000, pc_q};
                3'd3: prdata <= {5'h00, req_q};
                3'd4: prdata <= {22'h00_0000, done_q, busy, rdata_q};
                3'd5: prdata <= {24'h00_0000, code_q};
                3'd6: prdata <= pins_s;
                3'd7: prdata <= {31'h0000_0000, ale_dis_q};
                default: prdata <= (paddr == `EMB_OFS_MODE)
                                   ? {30'h0000_0000, rst_s, ext_exec}
                                   : 32'h0000_0000;
            endcase
        end
    end

    // disable only in plain internal cycles
    assign ale_block = ale_dis_eff_q && !ext_exec && !data_cyc;
    assign bus_active = ext_exec || data_cyc;
    assign addr = data_cyc ? req_q.addr : pc_q;
    // strobes in second half of a data cycle
    assign wr_n = !(data_cyc && half && sub < `EMB_STROBE_LO_SUBS
                    && req_q.write);
    assign rd_n = !(data_cyc && half && sub < `EMB_STROBE_LO_SUBS
                    && !req_q.write && !req_q.code_move);

    always_comb begin
        ale_out_d = 1'b1;
        ale_oe_d  = 1'b1;
        ale_wpu_d = 1'b0;
        program_fetch_strobe_d    = 1'b1;
        p0_d      = quasi(latch_q[7:0]);
        p0_d.wpu  = 8'h00;
        p1_d      = quasi(latch_q[15:8]);
        p2_d      = quasi(latch_q[23:16]);
        p3_d      = quasi(latch_q[31:24]);
        if (rst_s) begin
            // pins forced while reset is high
            p0_d = '{out: 8'hFF, oe: 8'h00, wpu: 8'h00};
            p1_d = quasi(8'hFF);
            p2_d = quasi(8'hFF);
            p3_d = quasi(8'hFF);
        end else begin
            if (ale_block) begin
                ale_out_d = 1'b0;
                ale_oe_d  = 1'b0;
                ale_wpu_d = 1'b1;
            end else begin
                // two pulses, second dropped in data cycle
                ale_out_d = sub < `EMB_ALE_HIGH_SUBS && !(data_cyc && half);
            end
            // fetch strobe only for external code
            if (!data_cyc && ext_exec && sub >= `EMB_ADDR_HOLD_SUBS) begin
                program_fetch_strobe_d = 1'b0;
            end
            if (data_cyc && req_q.code_move && half
                && sub < `EMB_STROBE_LO_SUBS) begin
                program_fetch_strobe_d = 1'b0;
            end
            if (bus_active) begin
                if (sub < `EMB_ADDR_HOLD_SUBS && !(data_cyc && half)) begin
                    p0_d = '{out: addr[7:0], oe: 8'hFF, wpu: 8'h00};
                end else if (data_cyc && half && req_q.write) begin
                    p0_d = '{out: req_q.wdata, oe: 8'hFF, wpu: 8'h00};
                end else begin
                    p0_d = '{out: 8'h00, oe: 8'h00, wpu: 8'h00};
                end
                if (!(data_cyc && req_q.indirect)) begin
                    p2_d = '{out: addr[15:8], oe: 8'hFF, wpu: 8'h00};
                end
            end
            if (data_cyc) begin
                p3_d.out[7:6] = {rd_n, wr_n};
                p3_d.oe[7:6]  = 2'b11;
                p3_d.wpu[7:6] = 2'b00;
            end
        end
    end

    // pins registered so no glitches reach the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_pins <= '{out: 8'hFF, oe: 8'h00, wpu: 8'h00};
            p1_pins <= '{out: 8'hFF, oe: 8'h00, wpu: 8'hFF};
            p2_pins <= '{out: 8'hFF, oe: 8'h00, wpu: 8'hFF};
            p3_pins <= '{out: 8'hFF, oe: 8'h00, wpu: 8'hFF};
            ale_out <= 1'b1;
            ale_oe  <= 1'b1;
            ale_wpu <= 1'b0;
            program_fetch_strobe_n <= 1'b1;
        end else begin
            p0_pins <= p0_d;
            p1_pins <= p1_d;
            p2_pins <= p2_d;
            p3_pins <= p3_d;
            ale_out <= ale_out_d;
            ale_oe  <= ale_oe_d;
            ale_wpu <= ale_wpu_d;
            program_fetch_strobe_n <= program_fetch_strobe_d;
        end
    end

    a_ale_rate: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (!data_cyc && phase_q == 4'h0 && !ale_block)
        |=> ale_out [*2] ##1 !ale_out [*4])
        else $error("latch strobe rate wrong");

    a_ale_skip: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (data_cyc && phase_q == 4'h6) |=> !ale_out [*6])
        else $error("latch strobe not skipped");

    a_addr_hold: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (bus_active && phase_q == 4'h1)
        |=> (p0_pins.oe == 8'hFF && ale_out)
        ##1 (p0_pins.oe == 8'hFF && !ale_out && $stable(p0_pins.out)))
        else $error("low address not held at strobe fall");

    a_program_fetch_strobe_idle: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (!ext_exec && !data_cyc) |=> program_fetch_strobe_n)
        else $error("fetch strobe active in internal execution");

    a_program_fetch_strobe_skip: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (data_cyc && phase_q == 4'h0 && !req_q.code_move)
        |=> program_fetch_strobe_n [*8] ##1 program_fetch_strobe_n [*4])
        else $error("fetch strobe not skipped in data cycle");

    a_strong_data: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (data_cyc && req_q.write && half)
        |=> (p0_pins.oe == 8'hFF && p0_pins.out == $past(req_q.wdata)))
        else $error("write data not strongly driven");

    a_p2_latch: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (data_cyc && req_q.indirect)
        |=> p2_pins.out == $past(latch_q[23:16]))
        else $error("high port lost latch in indirect access");

    a_wr_strobe: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        (data_cyc && req_q.write && phase_q == 4'h6)
        |=> !p3_pins.out[6] [*5] ##1 p3_pins.out[6])
        else $error("write strobe shape wrong");

    a_ale_off: assert property (@(posedge pclk)
        disable iff (!presetn || rst_s)
        ale_block |=> (!ale_oe && ale_wpu))
        else $error("disabled strobe still driven");

    a_rst_cancel: assert property (@(posedge pclk)
        disable iff (!presetn)
        int_rst |=> !ale_dis_q)
        else $error("reset left strobe disabled");

    a_rst_force: assert property (@(posedge pclk)
        disable iff (!presetn)
        rst_s |=> (p0_pins.oe == 8'h00 && p1_pins.wpu == 8'hFF))
        else $error("pins not forced during reset");
endmodule : emb_port

// [sim/emb_mem_model.sv]
// far-side code and data memory behind an address latch
`timescale 1ns/1ps
module emb_mem_model (
    input  wire logic        pclk,
    input  wire logic [7:0]  bus_lo,
    input  wire logic [7:0]  bus_hi,
    input  wire logic        ale_w,
    input  wire logic        fetch_n,
    input  wire logic        rd_n,
    output logic [7:0]       mem_data,
    output logic [15:0]      addr_q
);
    logic       ale_q  = 1'b0;
    logic [7:0] last_q = 8'h00;
    always_ff @(posedge pclk) begin
        ale_q <= ale_w;
        if (ale_q && !ale_w) begin
            addr_q <= {bus_hi, bus_lo};
        end
    end
    // drive only while strobed
    // released bus toggles so stale data never passes
    always_comb begin
        if (!fetch_n || !rd_n) begin
            mem_data = addr_q[7:0] + addr_q[15:8] + 8'h11;
        end else begin
            mem_data = ~last_q;
        end
    end
    always_ff @(posedge pclk) begin
        last_q <= mem_data;
    end
endmodule : emb_mem_model

// [sim/emb_port_tb_top.sv]
// self-checking bench for the external memory bus port
`timescale 1ns/1ps
`include "emb_cfg.svh"
module emb_port_tb_top;
    logic               pclk, presetn, psel, penable, pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rdat;
    logic               pready, pslverr, err, reset_pin, ext_sel, lock;
    emb_pkg::emb_pins_s p0_pins, p1_pins, p2_pins, p3_pins;
    logic               ale_out, ale_oe, ale_wpu, fetch_n, ale_w;
    logic [7:0]         mem_data, p0_w, p1_w, p2_w, p3_w, wr_lo, wr_oe;
    logic [15:0]        mem_addr, wr_addr, rd_addr;
    logic [1:0]         wr_ale;
    int                 num_errors, cmp_count, ale_cnt, fs_cnt;
    int                 wr_cnt, rd_cnt;
    // board pull-ups hold released lines of ports one to three high
    assign p0_w = (p0_pins.oe & p0_pins.out)
                | (~p0_pins.oe & (p0_pins.wpu | mem_data));
    assign p1_w = (p1_pins.oe & p1_pins.out) | ~p1_pins.oe;
    assign p2_w = (p2_pins.oe & p2_pins.out) | ~p2_pins.oe;
    assign p3_w = (p3_pins.oe & p3_pins.out) | ~p3_pins.oe;
    assign ale_w = ale_oe ? ale_out : ale_wpu;
    emb_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin(reset_pin),
        .external_fetch_select(ext_sel), .lock_programmed(lock),
        .p0_in(p0_w), .p1_in(p1_w), .p2_in(p2_w), .p3_in(p3_w),
        .p0_pins(p0_pins), .p1_pins(p1_pins), .p2_pins(p2_pins),
        .p3_pins(p3_pins), .ale_out(ale_out), .ale_oe(ale_oe),
        .ale_wpu(ale_wpu), .program_fetch_strobe_n(fetch_n));
    emb_mem_model u_mem (.pclk(pclk), .bus_lo(p0_w), .bus_hi(p2_w),
        .ale_w(ale_w), .fetch_n(fetch_n), .rd_n(p3_w[7]),
        .mem_data(mem_data), .addr_q(mem_addr));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick;
        @(posedge pclk);
        #1;
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            report_and_stop();
        end
    endtask : apb
    task automatic watch(input int n);
        logic a_q, f_q;
        tick();
        a_q = ale_w;
        f_q = fetch_n;
        ale_cnt = 0;
        fs_cnt = 0;
        wr_cnt = 0;
        rd_cnt = 0;
        wr_ale = 2'b00;
        repeat (n) begin
            tick();
            if (ale_w && !a_q) ale_cnt++;
            if (!fetch_n && f_q) fs_cnt++;
            if (!p3_w[6]) begin
                wr_cnt++;
                wr_lo = p0_pins.out;
                wr_oe = p0_pins.oe;
                wr_addr = mem_addr;
                wr_ale = {ale_oe, ale_wpu};
            end
            if (!p3_w[7]) begin
                rd_cnt++;
                rd_addr = mem_addr;
            end
            a_q = ale_w;
            f_q = fetch_n;
        end
    endtask : watch
    task automatic wait_rise;
        int n;
        n = 0;
        while (fetch_n !== 1'b0 && n < 40) begin
            tick();
            n++;
        end
        while (fetch_n !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        if (n >= 40) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_rise
    task automatic t_regs;
        tick();
        chk("p0 general", 32'({p0_pins.oe, p0_pins.wpu}), 0);
        chk("p1 general", 32'({p1_pins.oe, p1_pins.wpu}), 'hff);
        apb(1'b0, `EMB_OFS_LATCH, 0);
        chk("latch reset", rdat, 32'hffff_ffff);
        apb(1'b0, 12'(`EMB_OFS_ALE_CTRL), 0);
        chk("ale ctrl reset", 32'(rdat[0]), 0);
        apb(1'b0, 12'hffc, 0);
        chk("unmapped", 32'(err), 1);
        apb(1'b1, `EMB_OFS_MODE, 1);
        chk("mode write", 32'(err), 1);
        $display("register test done");
    endtask : t_regs
    task automatic t_write;
        apb(1'b1, `EMB_OFS_REQ, 32'h013c_a55a);
        watch(48);
        chk("ale in data", ale_cnt, 7);
        chk("fetch internal", fs_cnt, 0);
        chk("write strobe", wr_cnt, 5);
        chk("write data", 32'({wr_oe, wr_lo}), 'hff3c);
        chk("write addr", 32'(wr_addr), 'ha55a);
        apb(1'b0, `EMB_OFS_STAT, 0);
        chk("write done", 32'(rdat[9]), 1);
        apb(1'b1, `EMB_OFS_STAT, 32'h0000_0200);
        $display("write test done");
    endtask : t_write
    task automatic t_read;
        apb(1'b1, `EMB_OFS_LATCH, 32'hff77_ffff);
        apb(1'b1, `EMB_OFS_REQ, 32'h0200_005a);
        watch(48);
        chk("read strobe", rd_cnt, 5);
        chk("indirect hi", 32'(rd_addr), 'h775a);
        apb(1'b0, `EMB_OFS_STAT, 0);
        chk("read data", 32'(rdat[9:0]), 'h2e2);
        $display("read test done");
    endtask : t_read
    task automatic t_ext;
        logic [15:0] la;
        apb(1'b1, 12'(`EMB_OFS_ALE_CTRL), 32'h0000_0001);
        apb(1'b1, `EMB_OFS_FETCH, 32'h0000_1234);
        ext_sel <= 1'b0;
        repeat (30) @(posedge pclk);
        watch(24);
        chk("ale external", ale_cnt, 4);
        chk("fetch strobes", fs_cnt, 4);
        wait_rise();
        la = mem_addr;
        wait_rise();
        chk("next addr", 32'(mem_addr), 32'(la + 16'h0001));
        la = mem_addr;
        apb(1'b0, `EMB_OFS_CODE, 0);
        chk("code", 32'(rdat[7:0]), 32'(la[7:0] + la[15:8] + 8'h11));
        ext_sel <= 1'b1;
        repeat (30) @(posedge pclk);
        watch(24);
        chk("ale disabled", ale_cnt, 0);
        chk("ale weak", 32'({ale_oe, ale_wpu}), 1);
        apb(1'b1, `EMB_OFS_REQ, 32'h0155_0010);
        watch(48);
        chk("ale in move", 32'(wr_ale), 2);
        $display("external test done");
    endtask : t_ext
    task automatic t_reset;
        lock <= 1'b1;
        reset_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        tick();
        chk("p1 forced", 32'({p1_pins.oe, p1_pins.wpu}), 'hff);
        chk("p0 forced", 32'({p0_pins.oe, p0_pins.wpu}), 0);
        // held past two machine cycles
        repeat (30) @(posedge pclk);
        reset_pin <= 1'b0;
        ext_sel <= 1'b0;
        repeat (30) @(posedge pclk);
        apb(1'b0, 12'(`EMB_OFS_ALE_CTRL), 0);
        chk("disable cleared", 32'(rdat[0]), 0);
        apb(1'b0, `EMB_OFS_LATCH, 0);
        chk("latch after reset", rdat, 32'hffff_ffff);
        apb(1'b0, `EMB_OFS_MODE, 0);
        chk("strap held", 32'(rdat[0]), 0);
        watch(24);
        chk("ale resumed", ale_cnt, 4);
        chk("no fetch", fs_cnt, 0);
        $display("reset test done");
    endtask : t_reset
    initial begin
        num_errors = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        reset_pin = 1'b0;
        ext_sel = 1'b1;
        lock = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_write();
        t_read();
        t_ext();
        t_reset();
        report_and_stop();
    end
endmodule : emb_port_tb_top
